// ### rtl/abmi_consts.svh
/*
  Timing and width constants for the byte-wide MRAM host port.
  Assumes a 50 MHz system clock; every cycle count but the synchroniser latency is derived from a time in ns.
*/
`ifndef ABMI_CONSTS_SVH
`define ABMI_CONSTS_SVH

// Pin widths of the memory: 128K locations of one byte.
`define ABMI_ADDR_W 17
`define ABMI_DATA_W 8

// System clock period in ns.
`define ABMI_CLK_NS 20

// Device times in ns, as printed.
`define ABMI_T_CYC_NS     45
`define ABMI_T_ACC_NS     45
`define ABMI_T_WP_NS      20
`define ABMI_T_WREC_NS    12
`define ABMI_T_STARTUP_NS 2000000

// A least time rounds up to whole cycles.
`define ABMI_CEIL_CLKS(ns) (((ns) + `ABMI_CLK_NS - 1) / `ABMI_CLK_NS)

// Cycle counts derived from the times above.
`define ABMI_CYC_CLKS     `ABMI_CEIL_CLKS(`ABMI_T_CYC_NS)
`define ABMI_WP_CLKS      `ABMI_CEIL_CLKS(`ABMI_T_WP_NS)
`define ABMI_WREC_CLKS    `ABMI_CEIL_CLKS(`ABMI_T_WREC_NS)
`define ABMI_STARTUP_CLKS `ABMI_CEIL_CLKS(`ABMI_T_STARTUP_NS)

// Three synchroniser flops plus the agreement stage on the data pins.
`define ABMI_SYNC_CLKS 4

// Strobes stay low for access time plus synchroniser latency on a read.
`define ABMI_RD_CLKS (`ABMI_CEIL_CLKS(`ABMI_T_ACC_NS) + `ABMI_SYNC_CLKS)

`endif

// ### rtl/abmi_pkg.sv
/*
  Types shared by the MRAM host port: request and answer carriers, FSM states.
  Assumes abmi_consts.svh is on the include path.
*/
`include "abmi_consts.svh"

package abmi_pkg;

  // One access request from the user side.
  typedef struct packed {
    logic                    write;  // High for a byte write, low for a read.
    logic [`ABMI_ADDR_W-1:0] addr;   // Byte address.
    logic [`ABMI_DATA_W-1:0] wdata;  // Byte to write; ignored on reads.
  } abmi_req_t;

  // One answer to the user side.
  typedef struct packed {
    logic                    was_write;  // High when the finished access was a write.
    logic [`ABMI_DATA_W-1:0] rdata;      // Byte read; zero after a write.
  } abmi_rsp_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_IDLE,
    ST_READ,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_REC
  } abmi_state_t;

endpackage

// ### rtl/abmi_sync.sv
/*
  Three-flop synchroniser with agreement filter for a bus of pin inputs.
  Assumes one clock, an asynchronous active-low reset and a clock enable.
*/
`timescale 1ns/100ps

module abmi_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  logic [W-1:0] s1_q;  // First stage; read only by the second stage.
  logic [W-1:0] s2_q;  // Second stage.
  logic [W-1:0] s3_q;  // Third stage.

  // The chain itself; only the second stage looks at the first stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clk_en) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the second and third stages agree, which
  // filters a value that was caught mid-transition.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (clk_en && (s2_q == s3_q)) begin
      q <= s3_q;
    end
  end

endmodule

// ### rtl/abmi_host.sv
/*
  Host-side sequencer for an asynchronous byte-wide MRAM: turns user requests
  into chip-select, write-strobe, output-enable, address and data pin cycles.
  Assumes a 50 MHz clock, a pad ring that resolves the data pins from
  mem_dq_oe, and a memory that honours its own access and turn-off delays.
*/
// How it works
// RULE1 - Write strobe high during reads; reads spaced 45 ns.
// RULE2 - Data valid 45 ns after select falls.
// RULE3 - Data valid 20 ns after output enable falls.
// RULE4 - Old data held 3 ns after address change.
// RULE5 - Memory drivers start after select and enable.
// RULE6 - Memory floats bus within 15 ns of release.
// RULE7 - Writes happen only while select and strobe low.
// RULE8 - Enable after strobe keeps memory outputs floating.
// RULE9 - Raised select or strobe stays high 2 ns.
// RULE10 - Select falling edges spaced at least 45 ns.
// RULE11 - Write cycle 45 ns; address held 12 ns.
// RULE12 - Address valid at strobe fall, 25 ns before rise.
// RULE13 - Write strobe low at least 20 ns.
// RULE14 - Data set up 15 ns, held 0 ns.
// RULE15 - Memory drivers off 15 ns after strobe falls.
// RULE16 - Memory stays off 3 ns after strobe rises.
// RULE17 - Memory turn-off faster than its turn-on.
// RULE18 - Wait 2 ms, select and strobe high.
// RULE19 - Memory decodes select, strobe and enable.
`timescale 1ns/100ps
`include "abmi_consts.svh"

module abmi_host
  import abmi_pkg::*;
#(
  parameter int STARTUP_CLKS = `ABMI_STARTUP_CLKS
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    clk_en,
  input  wire logic                    req_valid,
  input  wire abmi_req_t               req,
  output      logic                    req_ready,
  output      logic                    rsp_valid,
  output      abmi_rsp_t               rsp,
  output      logic                    init_done,
  output      logic [`ABMI_ADDR_W-1:0] mem_addr,
  output      logic                    mem_ce_n,
  output      logic                    mem_we_n,
  output      logic                    mem_oe_n,
  output      logic [`ABMI_DATA_W-1:0] mem_dq_o,
  output      logic                    mem_dq_oe,
  input  wire logic [`ABMI_DATA_W-1:0] mem_dq_i
);

  abmi_state_t             state_q;    // Sequencer state.
  logic [2:0]              cnt_q;      // Cycles left in the current phase.
  logic [16:0]             start_q;    // Startup wait counter.
  logic [1:0]              gap_q;      // Cycles before select may fall again.
  logic [`ABMI_DATA_W-1:0] dq_sync;    // Filtered copy of the data pins.
  logic                    take;       // A request is accepted this cycle.
  logic                    ce_fall;    // Select is driven low at this edge.

  assign take    = (state_q == ST_IDLE) && req_ready && req_valid;
  // Reads lower select on acceptance; writes one cycle later, after setup.
  assign ce_fall = (take && !req.write) || (state_q == ST_WR_SETUP);

  // The data pins come from outside the clock domain.
  abmi_sync #(
    .W (`ABMI_DATA_W)
  ) u_dq_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .d      (mem_dq_i),
    .q      (dq_sync)
  );

  // Startup wait: nothing is issued until the memory has had its 2 ms.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q   <= 17'h00000;
      init_done <= 1'b0;
    end else if (clk_en && !init_done) begin
      if (start_q >= 17'(STARTUP_CLKS - 1)) begin
        init_done <= 1'b1; // RULE18
      end else begin
        start_q <= start_q + 17'h00001;
      end
    end
  end

  // Select spacing: a new falling edge waits a full cycle time after the last.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= 2'h0;
    end else if (clk_en) begin
      if (ce_fall) begin
        gap_q <= 2'(`ABMI_CYC_CLKS - 1); // RULE10
      end else if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end
    end
  end

  // Main sequencer: drives every memory pin and the user handshake.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= ST_STARTUP;
      cnt_q     <= 3'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp       <= '0;
      mem_addr  <= '0;
      mem_ce_n  <= 1'b1;
      mem_we_n  <= 1'b1;
      mem_oe_n  <= 1'b1;
      mem_dq_o  <= '0;
      mem_dq_oe <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        // Select and strobe stay high until the startup wait is over.
        ST_STARTUP: begin
          if (init_done) begin
            state_q   <= ST_IDLE; // RULE18
            req_ready <= 1'b1;
          end
        end
        // Pins idle high; at least one idle cycle separates accesses, which
        // also gives the memory time to float the bus before we drive it.
        ST_IDLE: begin
          if (take) begin
            req_ready <= 1'b0;
            mem_addr  <= req.addr;
            if (req.write) begin
              // Address and data go out one cycle before the strobes fall.
              mem_dq_o  <= req.wdata; // RULE12
              mem_dq_oe <= 1'b1;
              state_q   <= ST_WR_SETUP;
            end else begin
              // Address is valid no later than select falls; strobe stays high.
              mem_ce_n <= 1'b0; // RULE2
              mem_oe_n <= 1'b0; // RULE3
              mem_we_n <= 1'b1; // RULE1
              cnt_q    <= 3'(`ABMI_RD_CLKS - 1);
              state_q  <= ST_READ;
            end
          end else begin
            req_ready <= (gap_q == 2'h0); // RULE10
          end
        end
        // Hold select and enable for access time plus synchroniser latency,
        // then take the filtered byte. Slower than the pins allow, but safe.
        ST_READ: begin
          if (cnt_q == 3'h0) begin
            mem_ce_n      <= 1'b1; // RULE9
            mem_oe_n      <= 1'b1;
            rsp.was_write <= 1'b0;
            rsp.rdata     <= dq_sync; // RULE2
            rsp_valid     <= 1'b1;
            req_ready     <= 1'b1;
            state_q       <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        // Both strobes fall together; output enable stays high so the memory
        // never drives against our data.
        ST_WR_SETUP: begin
          mem_ce_n <= 1'b0; // RULE7
          mem_we_n <= 1'b0; // RULE8
          cnt_q    <= 3'(`ABMI_WP_CLKS - 1);
          state_q  <= ST_WR_PULSE;
        end
        // Strobe low for the write pulse width; address and data held.
        ST_WR_PULSE: begin
          if (cnt_q == 3'h0) begin
            mem_ce_n <= 1'b1; // RULE7
            mem_we_n <= 1'b1; // RULE13
            cnt_q    <= 3'(`ABMI_WREC_CLKS - 1);
            state_q  <= ST_WR_REC;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        // Address and data held through write recovery after the strobe rises.
        ST_WR_REC: begin
          if (cnt_q == 3'h0) begin
            mem_dq_oe     <= 1'b0; // RULE14
            rsp.was_write <= 1'b1;
            rsp.rdata     <= '0;
            rsp_valid     <= 1'b1;
            req_ready     <= 1'b1; // RULE11
            state_q       <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= ST_STARTUP;
        end
      endcase
    end
  end

  // Checks run only on enabled edges, since a frozen clock stretches every phase.
  default clocking cb @(posedge clk iff clk_en);
  endclocking
  default disable iff (!arst_n);

  a_read_we_high: assert property (!mem_oe_n |-> mem_we_n) // RULE1
    else $error("write strobe low while output enabled");

  a_read_hold_len: assert property ($fell(mem_oe_n) |-> // RULE2
    (!mem_ce_n && !mem_oe_n)[*7] ##1 (mem_ce_n && rsp_valid && !rsp.was_write))
    else $error("read strobes not held for full access window");

  a_write_in_sel: assert property (!mem_we_n |-> !mem_ce_n) // RULE7
    else $error("write strobe low outside chip select");

  a_no_contend: assert property (mem_dq_oe |-> mem_oe_n) // RULE8
    else $error("host drives data while memory output enabled");

  // A strobe may fall only after both strobes stood high for a whole cycle;
  // back-to-back reads give select exactly one high cycle, which is enough.
  a_high_time: assert property (($fell(mem_ce_n) || $fell(mem_we_n)) |-> // RULE9
    ($past(mem_ce_n) && $past(mem_we_n)))
    else $error("strobe lowered without a full high cycle");

  a_sel_spacing: assert property ($fell(mem_ce_n) |=> (!$fell(mem_ce_n))[*2]) // RULE10
    else $error("select falling edges closer than cycle time");

  a_addr_recover: assert property ($rose(mem_we_n) |-> // RULE11
    $stable(mem_addr) ##1 $stable(mem_addr))
    else $error("address changed during write recovery");

  a_addr_setup: assert property ($fell(mem_we_n) |-> // RULE12
    ($stable(mem_addr) && $past(mem_dq_oe)))
    else $error("address not set up before write strobe");

  a_pulse_width: assert property ($fell(mem_we_n) |-> !mem_we_n ##1 mem_we_n) // RULE13
    else $error("write pulse width wrong");

  // Data is driven before and still at the rise; it is released the cycle after.
  a_data_setup: assert property ($rose(mem_we_n) |-> // RULE14
    (mem_dq_oe && $past(mem_dq_oe) && $stable(mem_dq_o)))
    else $error("write data not held around strobe rise");

  a_startup_quiet: assert property (!init_done |-> (mem_ce_n && mem_we_n && !req_ready)) // RULE18
    else $error("memory accessed before startup wait");

  c_read_done:  cover property (rsp_valid && !rsp.was_write);
  c_write_done: cover property (rsp_valid && rsp.was_write);
  c_wr_then_rd: cover property ($rose(mem_we_n) ##[1:6] $fell(mem_oe_n));
  c_init:       cover property ($rose(init_done));

endmodule

// ### tb/abmi_mem_model.sv
/*
  Behavioural byte memory on the far side of the host port; it counts host timing breaches.
  Assumes the bench resolves the data pins from the host's enable alone.
*/
`timescale 1ns/100ps

module abmi_mem_model (
  input  wire logic        slow,
  input  wire logic        host_oe,
  input  wire logic [16:0] addr,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  dq_in,
  output      logic [7:0]  dq_out,
  output      logic        dq_en,
  output      logic [15:0] viol
);
  logic [7:0] mem [int];  // Sparse store; unwritten bytes read as zero.
  logic       armed = 1'b0;  // A write overlap has begun.
  realtime    t_ce = -1.0E3, t_up = -1.0E3, t_wf = -1.0E3, t_wr = -1.0E3, t_a = -1.0E3;
  realtime    t_d = -1.0E3;  // Last change of the data pins.
  wire        rd = !ce_n && we_n && !oe_n;
  wire        wr = !ce_n && !we_n;

  function automatic logic [7:0] rdat(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction

  // Quiet bus with an arbitrary float pattern.
  initial begin
    dq_en = 1'b0;
    dq_out = 8'h5A;
    viol = 16'h0000;
  end

  // Junk after the hold time, then the byte; the slow mode uses the full access time.
  always @(rd or addr) begin
    if (rd) begin
      dq_en <= #3 1'b1;
      dq_out <= #3 ~dq_out;
      dq_out <= #(slow ? 45 : 8) rdat(addr);
    end
  end

  // Release leaves the inverse of the last byte, since a floating bus keeps no value.
  always @(negedge rd) begin
    dq_en <= #(slow ? 15 : 4) 1'b0;
    dq_out <= #(slow ? 15 : 4) ~dq_out;
  end

  // The byte is stored when the select and strobe overlap ends.
  always @(posedge wr) armed = 1'b1;
  always @(negedge wr) begin
    if (armed) mem[addr] = dq_in;
    armed = 1'b0;
  end

  // Host-side timing; every breach is counted for the bench.
  always @(dq_en or host_oe) if (dq_en && host_oe) viol++;
  always @(posedge ce_n or posedge we_n) t_up = $realtime;
  always @(dq_in) t_d = $realtime;
  always @(negedge ce_n) begin
    if ($realtime - t_ce < 45 || $realtime - t_up < 2) viol++;
    t_ce = $realtime;
  end
  always @(negedge we_n) begin
    if ($realtime - t_up < 2 || !oe_n) viol++;
    t_wf = $realtime;
  end
  always @(posedge we_n) begin
    if (t_wf > t_wr) begin
      if ($realtime - t_wf < 20) viol++;
      if ($realtime - t_a < 25 || $realtime - t_d < 15) viol++;
      t_wr = $realtime;
    end
  end
  always @(addr) begin
    if ($realtime - t_wr < 12 || $realtime - t_a < 45) viol++;
    t_a = $realtime;
  end
endmodule

// ### tb/async_byte_mram_interface_tb.sv
/*
  Self-checking bench: the host port drives a behavioural byte memory.
  Assumes the design files and abmi_mem_model.sv are compiled before it.
*/
`timescale 1ns/100ps

module async_byte_mram_interface_tb;
  import abmi_pkg::*;
  localparam int SU = 4;  // Short startup wait keeps the run brief.
  logic        clk, arst_n, clk_en, req_valid, slow, jitter;
  logic        req_ready, rsp_valid, init_done, ce_n, we_n, oe_n, dq_oe, m_en;
  abmi_req_t   req;
  abmi_rsp_t   rsp;
  logic [16:0] addr;
  logic [7:0]  dq_o, m_out;
  logic [15:0] viol;
  int          miscompares, total_checks, cyc;
  logic [7:0]  shadow [int];  // Expected memory contents.
  wire  [7:0]  dq = dq_oe ? dq_o : m_out;  // Resolved data pins.

  abmi_host #(.STARTUP_CLKS(SU)) dut (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done),
    .mem_addr(addr), .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq));
  abmi_mem_model far (
    .slow(slow), .host_oe(dq_oe), .addr(addr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .dq_in(dq), .dq_out(m_out), .dq_en(m_en), .viol(viol));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hang is cut short; the tests need under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // Random enable gaps stretch every phase of an access; this is the only
  // place that moves the enable after time zero, so it never races the tasks.
  always @(negedge clk) begin
    clk_en = jitter ? (($urandom % 3) != 0) : 1'b1;
  end

  // Expected answer byte: zero after a write, else the last byte written there.
  function automatic logic [7:0] exp_byte(input logic w, input logic [16:0] a);
    return w ? 8'h00 : (shadow.exists(a) ? shadow[a] : 8'h00);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset for two cycles, then the strobes must stay high through startup.
  task automatic do_reset();
    int n;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    check({ce_n, we_n, oe_n, dq_oe, init_done, req_ready}, 6'h38);
    arst_n = 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
      check({ce_n, we_n}, 2'h3);
    end
    check(n, SU);
  endtask

  // One request; the answer is checked against the shadow copy.
  task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d,
                        input logic lat);
    int n;
    logic [7:0] exp;
    exp = exp_byte(w, a);
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    n = 0;
    // Hold the request until ready was seen high and then dropped by the take,
    // so a disabled edge in between only stretches the hold.
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    while (req_ready === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (w) shadow[a] = d;
    check({23'h0, rsp.was_write, rsp.rdata}, {23'h0, w, exp});
    if (lat) check(n, w ? 32'h4 : 32'h8);
  endtask

  initial begin
    clk_en = 1'b1;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b1;
    jitter = 1'b0;
    void'($urandom(88));
    do_reset();
    $display("test startup done");
    access(1'b1, 17'h00000, 8'hFF, 1'b1);
    access(1'b1, 17'h1FFFF, 8'h00, 1'b1);
    access(1'b0, 17'h00000, 8'h00, 1'b1);
    access(1'b0, 17'h1FFFF, 8'h00, 1'b1);
    access(1'b1, 17'h1FFFF, 8'hA5, 1'b1);
    access(1'b0, 17'h1FFFF, 8'h00, 1'b1);
    $display("test corners done");
    slow = 1'b0;
    jitter = 1'b1;
    repeat (80) access(1'($urandom), 17'($urandom) & 17'h1000F, 8'($urandom), 1'b0);
    jitter = 1'b0;
    $display("test random done");
    // A reset in mid-read must idle the pins while the memory keeps its data.
    req_valid = 1'b1;
    req = '{write: 1'b0, addr: 17'h1FFFF, wdata: 8'h00};
    repeat (4) @(negedge clk);
    req_valid = 1'b0;
    do_reset();
    access(1'b0, 17'h1FFFF, 8'h00, 1'b1);
    $display("test reset in read done");
    check({31'h0, m_en}, 32'h0);
    check({16'h0, viol}, 32'h0);
    close_out();
  end
endmodule
